// [rtl/imp_pkg.sv]
// package: register map, field layout and exception codes of the interrupt block
package imp_pkg;
   // ==========================================================
   // register addresses
   localparam logic [31:0] ADDR_SYS_CTRL = 32'hffb00000;
   localparam logic [31:0] ADDR_MASK = 32'hffb00030;
   localparam logic [31:0] ADDR_MASKED = 32'hffb00034;
   localparam logic [31:0] ADDR_RAW = 32'hffb00038;
   localparam logic [31:0] ADDR_DMA_BASE = 32'hff900014;
   localparam logic [31:0] DMA_STRIDE = 32'h00000020;
   localparam int DMA_STRIDE_LOG2 = 5;
   // ==========================================================
   // reset values and writable bits
   localparam logic [31:0] MASK_RESET = 32'h00000000;
   localparam logic [31:0] MASK_WRITABLE = 32'hfffff07f;
   // ==========================================================
   // status bit positions
   localparam int BIT_DMA_TOP = 31;
   localparam int BIT_EXT_TOP = 21;
   localparam int BIT_ETH_RX = 17;
   localparam int BIT_ETH_TX = 16;
   localparam int BIT_SER_TOP = 15;
   localparam int BIT_WATCHDOG = 6;
   localparam int BIT_TIMER1 = 5;
   localparam int BIT_TIMER2 = 4;
   localparam int BIT_PIN_TOP = 3;
   localparam int NUM_DMA_SRC = 10;
   // ==========================================================
   // dma pending flags, top nibble of a channel status word
   localparam int DMA_FLAG_LSB = 28;
   localparam int DMA_FLAGS = 4;
   // ==========================================================
   // watchdog response select in the system control word
   localparam int WD_SEL_LSB = 22;
   localparam logic [1:0] WD_SEL_RESET_VAL = 2'h0;
   localparam logic [1:0] WD_NORMAL = 2'h0;
   localparam logic [1:0] WD_FAST = 2'h1;
   localparam logic [1:0] WD_SYS_RESET = 2'h2;
   // ==========================================================
   // exceptions taken by the core, in fixed priority order
   typedef enum logic [2:0] {
      EXC_NONE,
      EXC_RESET,
      EXC_DABORT,
      EXC_FAST,
      EXC_NORMAL,
      EXC_PABORT,
      EXC_UNDEF,
      EXC_TRAP
   } imp_exc_e;
endpackage

// [rtl/imp_top.sv]
// interrupt mask, status views, fast/normal routing and exception priority
//
// Contract
// - mask bit gates source onto normal line
// - raw status shows active requests not routed to the fast line or to reset
// - masked status equals raw AND mask
// - normal line is OR of masked
// - status registers read-only, writes ignored
// - no latching here except the dma pending flags; other sources hold causes
// - upper status half bit layout
// - lower status half bit layout
// - only timers and watchdog drive fast
// - fast preempts normal in service
// - fast disable flag, not set by user
// - sample synchronized fast low at instruction end
// - fixed exception priority order
// - undefined and trap never together
// - abort with fast: abort, then fast
// - dma channel holds four pending flags
// - write one clears dma flag
// - dma status registers at stride offsets
// - watchdog selects normal, fast or reset
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module imp_top
   import imp_pkg::*;
#(
   parameter int NUM_DMA_CH = 13,
   parameter int NUM_ETH_SUB = 4
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [4*NUM_DMA_CH-1:0] dma_event,
   input wire logic [3:0] external_host_port_req,
   input wire logic ethernet_port_rx_req,
   input wire logic ethernet_port_tx_req,
   input wire logic [3:0] serial_req,
   input wire logic watchdog_expired,
   input wire logic timer1_req,
   input wire logic timer2_req,
   input wire logic timer1_fast,
   input wire logic timer2_fast,
   input wire logic port_pin_three,
   input wire logic [1:0] port_pin_mid,
   input wire logic port_pin_zero,
   output logic normal_irq,
   output logic fast_irq_n,
   output logic watchdog_sys_reset,
   input wire logic core_reset_req,
   input wire logic data_abort,
   input wire logic prefetch_abort,
   input wire logic undef_instr,
   input wire logic software_trap,
   input wire logic instr_end,
   input wire logic user_mode,
   input wire logic normal_disable,
   input wire logic fd_write,
   input wire logic fd_wdata,
   input wire logic fast_return,
   output logic fast_disable,
   output logic exc_take,
   output imp_exc_e exc_code
);
   // ==========================================================
   // elaboration checks
   if (NUM_DMA_CH - NUM_ETH_SUB + 1 != NUM_DMA_SRC) begin : g_bad_dma
      $error("dma channel count does not fit the ten dma status bits");
   end

   // ==========================================================
   // apb decode
   logic setup;
   logic wr_access;
   logic [31:0] dma_off;
   logic dma_hit;
   logic [31:0] dma_idx;
   logic [31:0] wd_mask_reg;
   logic [1:0] wd_sel_reg;
   logic [31:0] raw;
   logic [31:0] masked;
   logic [DMA_FLAGS-1:0] dma_pend [NUM_DMA_CH];

   assign setup = psel && !penable;
   assign wr_access = psel && penable && pwrite;
   assign pready = 1'b1;
   // dma status words repeat at a fixed stride from the base
   assign dma_off = paddr - ADDR_DMA_BASE;
   assign dma_idx = dma_off >> DMA_STRIDE_LOG2;
   assign dma_hit = (dma_off[DMA_STRIDE_LOG2-1:0] == '0) && (dma_idx < NUM_DMA_CH);

   // ==========================================================
   // interrupt enable mask, bits eleven to seven held at zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wd_mask_reg <= MASK_RESET;
      end else if (wr_access && paddr == ADDR_MASK) begin
         wd_mask_reg <= pwdata & MASK_WRITABLE;
      end
   end

   // watchdog response select held in the system control word
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wd_sel_reg <= WD_SEL_RESET_VAL;
      end else if (wr_access && paddr == ADDR_SYS_CTRL) begin
         wd_sel_reg <= pwdata[WD_SEL_LSB+1:WD_SEL_LSB];
      end
   end

   // ==========================================================
   // dma pending flags: event sets, write one clears, set wins
   for (genvar c = 0; c < NUM_DMA_CH; c++) begin : g_dma
      logic [DMA_FLAGS-1:0] pend_reg;
      logic [DMA_FLAGS-1:0] clr;
      assign clr = (wr_access && dma_hit && dma_idx == c) ?
                   pwdata[DMA_FLAG_LSB+DMA_FLAGS-1:DMA_FLAG_LSB] : '0;
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            pend_reg <= '0;
         end else begin
            pend_reg <= (pend_reg & ~clr) | dma_event[DMA_FLAGS*c +: DMA_FLAGS];
         end
      end
      assign dma_pend[c] = pend_reg;
   end

   // dma sources: ethernet receive sub-channels share the first bit
   logic [NUM_DMA_SRC-1:0] dma_src;
   always_comb begin
      dma_src = '0;
      for (int c = 0; c < NUM_DMA_CH; c++) begin
         if (c < NUM_ETH_SUB) begin
            dma_src[0] = dma_src[0] | (|dma_pend[c]);
         end else begin
            dma_src[c-NUM_ETH_SUB+1] = |dma_pend[c];
         end
      end
   end

   // ==========================================================
   // raw status: sources routed to the fast line do not show here
   logic wd_normal;
   logic wd_fast;
   logic t1_normal;
   logic t2_normal;
   assign wd_normal = watchdog_expired && wd_sel_reg == WD_NORMAL;
   assign wd_fast = watchdog_expired && wd_sel_reg == WD_FAST;
   assign watchdog_sys_reset = watchdog_expired && wd_sel_reg == WD_SYS_RESET;
   assign t1_normal = timer1_req && !timer1_fast;
   assign t2_normal = timer2_req && !timer2_fast;

   // plain wiring of the source levels, nothing latched here
   always_comb begin
      raw = '0;
      for (int k = 0; k < NUM_DMA_SRC; k++) begin
         raw[BIT_DMA_TOP-k] = dma_src[k];
      end
      raw[BIT_EXT_TOP -: 4] = external_host_port_req;
      raw[BIT_ETH_RX] = ethernet_port_rx_req;
      raw[BIT_ETH_TX] = ethernet_port_tx_req;
      raw[BIT_SER_TOP -: 4] = serial_req;
      raw[BIT_WATCHDOG] = wd_normal;
      raw[BIT_TIMER1] = t1_normal;
      raw[BIT_TIMER2] = t2_normal;
      raw[BIT_PIN_TOP -: 4] = {port_pin_three, port_pin_mid, port_pin_zero};
   end

   assign masked = raw & wd_mask_reg;
   assign normal_irq = |masked;
   assign fast_irq_n = !(wd_fast || (timer1_req && timer1_fast) ||
                         (timer2_req && timer2_fast));

   // ==========================================================
   // read data captured in setup so it stands through the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
         pslverr <= 1'b0;
      end else if (setup) begin
         pslverr <= 1'b0;
         prdata <= '0;
         if (paddr == ADDR_MASK) begin
            prdata <= wd_mask_reg;
         end else if (paddr == ADDR_MASKED) begin
            prdata <= masked;
         end else if (paddr == ADDR_RAW) begin
            prdata <= raw;
         end else if (paddr == ADDR_SYS_CTRL) begin
            prdata[WD_SEL_LSB+1:WD_SEL_LSB] <= wd_sel_reg;
         end else if (dma_hit) begin
            prdata[DMA_FLAG_LSB+DMA_FLAGS-1:DMA_FLAG_LSB] <= dma_pend[dma_idx];
         end else begin
            pslverr <= 1'b1;
         end
      end
   end

   // ==========================================================
   // core side: fast request synchroniser
   logic fast_meta_reg;
   logic fast_sync_reg;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fast_meta_reg <= 1'b1;
         fast_sync_reg <= 1'b1;
      end else begin
         fast_meta_reg <= fast_irq_n;
         fast_sync_reg <= fast_meta_reg;
      end
   end

   // fast disable flag: set on reset and fast entry, user writes ignored
   logic fd_reg;
   logic take_fast;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fd_reg <= 1'b1;
      end else if (take_fast) begin
         fd_reg <= 1'b1;
      end else if (fast_return) begin
         fd_reg <= 1'b0;
      end else if (fd_write && !user_mode) begin
         fd_reg <= fd_wdata;
      end
   end
   assign fast_disable = fd_reg;

   // ==========================================================
   // exception priority resolver
   logic fast_ok;
   logic normal_ok;
   logic in_fast_reg;
   logic chain_reg;
   imp_exc_e exc_next;
   assign fast_ok = !fd_reg && !fast_sync_reg;
   // normal is held off while a fast handler runs; fast preempts normal
   assign normal_ok = !normal_disable && normal_irq && !in_fast_reg;

   always_comb begin
      exc_next = EXC_NONE;
      if (chain_reg) begin
         exc_next = EXC_FAST;
      end else if (instr_end) begin
         if (core_reset_req) begin
            exc_next = EXC_RESET;
         end else if (data_abort) begin
            exc_next = EXC_DABORT;
         end else if (fast_ok) begin
            exc_next = EXC_FAST;
         end else if (normal_ok) begin
            exc_next = EXC_NORMAL;
         end else if (prefetch_abort) begin
            exc_next = EXC_PABORT;
         end else if (undef_instr) begin
            exc_next = EXC_UNDEF;
         end else if (software_trap) begin
            exc_next = EXC_TRAP;
         end
      end
   end
   assign take_fast = exc_next == EXC_FAST;

   // abort taken with an enabled fast request chains into fast entry
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chain_reg <= 1'b0;
      end else begin
         chain_reg <= instr_end && !core_reset_req && data_abort && fast_ok;
      end
   end

   // fast handler occupancy
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         in_fast_reg <= 1'b0;
      end else if (take_fast) begin
         in_fast_reg <= 1'b1;
      end else if (fast_return) begin
         in_fast_reg <= 1'b0;
      end
   end

   // registered exception report
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         exc_take <= 1'b0;
         exc_code <= EXC_NONE;
      end else begin
         exc_take <= exc_next != EXC_NONE;
         exc_code <= exc_next;
      end
   end

   // ==========================================================
   // assertions
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_mask_write;
      wr_access && paddr == ADDR_MASK |=> wd_mask_reg == ($past(pwdata) & MASK_WRITABLE);
   endproperty
   a_mask_write: assert property (p_mask_write) else $error("mask write lost");

   property p_masked_read;
      setup && paddr == ADDR_MASKED |=> prdata == ($past(raw) & $past(wd_mask_reg));
   endproperty
   a_masked_read: assert property (p_masked_read) else $error("masked read wrong");

   property p_status_ro;
      wr_access && (paddr == ADDR_RAW || paddr == ADDR_MASKED) |=>
         $stable(wd_mask_reg) && $stable(wd_sel_reg);
   endproperty
   a_status_ro: assert property (p_status_ro) else $error("status write changed state");

   property p_gap_zero;
      wd_mask_reg[11:7] == 5'h00 && masked[11:7] == 5'h00;
   endproperty
   a_gap_zero: assert property (p_gap_zero) else $error("unassigned bits set");

   property p_fast_source;
      !fast_irq_n |-> timer1_req || timer2_req || watchdog_expired;
   endproperty
   a_fast_source: assert property (p_fast_source) else $error("bad fast source");

   property p_user_fd;
      fd_write && user_mode && !take_fast && !fast_return |=> $stable(fd_reg);
   endproperty
   a_user_fd: assert property (p_user_fd) else $error("user changed fast disable");

   property p_dma_clear;
      wr_access && dma_hit && dma_idx == 0 && pwdata[31] && !dma_event[3] |=> !dma_pend[0][3];
   endproperty
   a_dma_clear: assert property (p_dma_clear) else $error("dma flag not cleared");

   property p_reset_first;
      instr_end && core_reset_req && !chain_reg |=> exc_take && exc_code == EXC_RESET;
   endproperty
   a_reset_first: assert property (p_reset_first) else $error("reset not first");

   sequence s_abort_with_fast;
      instr_end && !core_reset_req && data_abort && fast_ok && !chain_reg;
   endsequence
   sequence s_abort_then_fast;
      exc_code == EXC_DABORT ##1 exc_code == EXC_FAST;
   endsequence
   property p_abort_chain;
      s_abort_with_fast |=> s_abort_then_fast;
   endproperty
   a_abort_chain: assert property (p_abort_chain) else $error("abort did not chain to fast");

   property p_normal_line;
      normal_irq == (|masked);
   endproperty
   a_normal_line: assert property (p_normal_line) else $error("normal line mismatch");

   property p_mask_off;
      wd_mask_reg == 32'h00000000 |-> !normal_irq;
   endproperty
   a_mask_off: assert property (p_mask_off) else $error("masked source reached line");

   // a normal request is not taken while the fast handler runs
   property p_fast_holds_normal;
      in_fast_reg |=> exc_code != EXC_NORMAL;
   endproperty
   a_fast_holds_normal: assert property (p_fast_holds_normal) else $error("normal in fast");
endmodule
`default_nettype wire

// [rtl/imp_top_unused_placeholder_removed.sv]
// intentionally empty companion file holding no logic
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// [tb/imp_core_model.sv]
// core-side partner model: paces instruction ends for the exception resolver
`timescale 1ns/1ps
`default_nettype none
module imp_core_model
   import imp_pkg::*;
#(
   parameter int GAP = 3
) (
   input wire logic pclk,
   input wire logic presetn,
   output logic instr_end
);
   int cnt;
   // ==========================================================
   // instruction pacing
   // one-cycle end pulse every GAP cycles; a larger GAP models a slow core
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 0;
         instr_end <= 1'b0;
      end else begin
         cnt <= (cnt >= GAP - 1) ? 0 : cnt + 1;
         instr_end <= (cnt == GAP - 1);
      end
   end
endmodule
`default_nettype wire

// [tb/imp_top_tb_top.sv]
// self-checking bench for the interrupt mask, status views and exception priority
`timescale 1ns/1ps
`default_nettype none
module imp_top_tb_top
   import imp_pkg::*;
;
   localparam logic [31:0] DMA_CH12 = 32'hff900194;
   localparam logic [31:0] NOWHERE = 32'hffb00040;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
   logic [31:0] paddr, pwdata, prdata, src, rdat;
   logic [51:0] dev;
   logic [4:0] lv;
   logic t1f, t2f, nd, um, fdw, fdd, fret;
   logic normal_irq, fast_irq_n, wd_rst, fast_disable, exc_take, instr_end;
   imp_exc_e exc_code;
   int failures = 0;
   int samples_checked = 0;
   // table rows: sources, mask written, mask read, raw, masked
   logic [31:0] rows [5][5] = '{
      '{32'h003ff07f, 32'h00000000, 32'h00000000, 32'h003ff07f, 32'h00000000},
      '{32'h003ff07f, 32'hffffffff, 32'hfffff07f, 32'h003ff07f, 32'h003ff07f},
      '{32'h00000001, 32'h00000001, 32'h00000001, 32'h00000001, 32'h00000001},
      '{32'h00200000, 32'h001fffff, 32'h001ff07f, 32'h00200000, 32'h00000000},
      '{32'h00008050, 32'h00008010, 32'h00008010, 32'h00008050, 32'h00008010}};
   // ==========================================================
   // design and partner
   imp_top i_imp_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .dma_event(dev), .external_host_port_req(src[21:18]),
      .ethernet_port_rx_req(src[17]), .ethernet_port_tx_req(src[16]),
      .serial_req(src[15:12]), .watchdog_expired(src[6]), .timer1_req(src[5]),
      .timer2_req(src[4]), .timer1_fast(t1f), .timer2_fast(t2f),
      .port_pin_three(src[3]), .port_pin_mid(src[2:1]), .port_pin_zero(src[0]),
      .normal_irq(normal_irq), .fast_irq_n(fast_irq_n), .watchdog_sys_reset(wd_rst),
      .core_reset_req(lv[4]), .data_abort(lv[3]), .prefetch_abort(lv[2]),
      .undef_instr(lv[1]), .software_trap(lv[0]), .instr_end(instr_end), .user_mode(um),
      .normal_disable(nd), .fd_write(fdw), .fd_wdata(fdd), .fast_return(fret),
      .fast_disable(fast_disable), .exc_take(exc_take), .exc_code(exc_code));
   imp_core_model #(.GAP(3)) i_imp_core_model (.pclk(pclk), .presetn(presetn),
      .instr_end(instr_end));
   // clock
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   // ==========================================================
   // tasks
   task automatic results();
      if (failures == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one apb transfer, held until pready is seen high
   task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         failures++;
         results();
      end
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rdat, exp);
   endtask
   // wait, bounded, for the next exception entry pulse
   task automatic wait_take();
      int k;
      k = 0;
      do begin
         @(negedge pclk);
         k++;
      end while (exc_take !== 1'b1 && k < 40);
      if (k >= 40) begin
         failures++;
         results();
      end
   endtask
   // raise levels right after an instruction end, so a fast request is
   // through the synchroniser when the next end comes; then return and settle
   task automatic take(input logic [4:0] l, input logic n_d, input logic f,
      input imp_exc_e e, input imp_exc_e e2);
      int k;
      k = 0;
      do begin
         @(negedge pclk);
         k++;
      end while (instr_end !== 1'b1 && k < 40);
      if (k >= 40) begin
         failures++;
         results();
      end
      @(posedge pclk);
      lv <= l;
      nd <= n_d;
      t1f <= f;
      wait_take();
      chk({29'h0, exc_code}, {29'h0, e});
      if (e2 != EXC_NONE) begin
         @(negedge pclk);
         chk({29'h0, exc_code}, {29'h0, e2});
      end
      @(posedge pclk);
      lv <= 5'h0;
      nd <= 1'b1;
      t1f <= 1'b0;
      repeat (3) @(posedge pclk);
      fret <= 1'b1;
      @(posedge pclk);
      fret <= 1'b0;
      repeat (3) @(posedge pclk);
   endtask
   // ==========================================================
   // main sequence
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 32'h0;
      pwdata = 32'h0;
      src = 32'h0;
      dev = 52'h0;
      lv = 5'h0;
      {t1f, t2f, um, fdw, fdd, fret} = 6'h0;
      nd = 1'b1;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      chk({31'h0, fast_disable}, 32'h1);
      rdchk(ADDR_MASK, MASK_RESET);
      for (int i = 0; i < 5; i++) begin
         src <= rows[i][0];
         apb(1'b1, ADDR_MASK, rows[i][1]);
         rdchk(ADDR_MASK, rows[i][2]);
         rdchk(ADDR_RAW, rows[i][3]);
         rdchk(ADDR_MASKED, rows[i][4]);
         chk({31'h0, normal_irq}, {31'h0, |rows[i][4]});
      end
      apb(1'b1, ADDR_RAW, 32'h0);
      apb(1'b1, ADDR_MASKED, 32'h0);
      rdchk(ADDR_RAW, 32'h00008050);
      rdchk(ADDR_MASK, 32'h00008010);
      apb(1'b1, NOWHERE, 32'hffffffff);
      chk({31'h0, rerr}, 32'h1);
      rdchk(NOWHERE, 32'h0);
      // dma flags latch, clear on one, survive a zero
      src <= 32'h0;
      dev <= 52'h8;
      @(posedge pclk);
      dev <= 52'h0;
      rdchk(ADDR_DMA_BASE, 32'h80000000);
      rdchk(ADDR_RAW, 32'h80000000);
      apb(1'b1, ADDR_DMA_BASE, 32'h0);
      rdchk(ADDR_DMA_BASE, 32'h80000000);
      apb(1'b1, ADDR_DMA_BASE, 32'h80000000);
      rdchk(ADDR_DMA_BASE, 32'h0);
      dev <= 52'h1 << 48;
      @(posedge pclk);
      dev <= 52'h0;
      rdchk(DMA_CH12, 32'h10000000);
      rdchk(ADDR_RAW, 32'h00400000);
      apb(1'b1, DMA_CH12, 32'h10000000);
      // fast line routing and watchdog response
      src <= 32'h20;
      t1f <= 1'b1;
      rdchk(ADDR_RAW, 32'h0);
      chk({31'h0, fast_irq_n}, 32'h0);
      src <= 32'h10;
      t1f <= 1'b0;
      t2f <= 1'b1;
      rdchk(ADDR_RAW, 32'h0);
      chk({31'h0, fast_irq_n}, 32'h0);
      src <= 32'h0000f00f;
      t2f <= 1'b0;
      @(negedge pclk);
      chk({31'h0, fast_irq_n}, 32'h1);
      apb(1'b1, ADDR_SYS_CTRL, 32'h00400000);
      src <= 32'h40;
      @(negedge pclk);
      chk({31'h0, fast_irq_n}, 32'h0);
      apb(1'b1, ADDR_SYS_CTRL, 32'h00800000);
      @(negedge pclk);
      chk({30'h0, wd_rst, fast_irq_n}, 32'h3);
      apb(1'b1, ADDR_SYS_CTRL, 32'h0);
      // fast-disable flag cannot be set from user mode
      src <= 32'h1;
      apb(1'b1, ADDR_MASK, 32'h1);
      fret <= 1'b1;
      @(posedge pclk);
      fret <= 1'b0;
      um <= 1'b1;
      fdw <= 1'b1;
      fdd <= 1'b1;
      @(posedge pclk);
      fdw <= 1'b0;
      um <= 1'b0;
      @(negedge pclk);
      chk({31'h0, fast_disable}, 32'h0);
      @(posedge pclk);
      // a privileged write sets and then clears the flag
      fdw <= 1'b1;
      @(posedge pclk);
      fdd <= 1'b0;
      @(negedge pclk);
      chk({31'h0, fast_disable}, 32'h1);
      @(posedge pclk);
      fdw <= 1'b0;
      @(negedge pclk);
      chk({31'h0, fast_disable}, 32'h0);
      // exception priority, then fast interplay
      take(5'b11111, 1'b0, 1'b0, EXC_RESET, EXC_NONE);
      take(5'b01111, 1'b0, 1'b0, EXC_DABORT, EXC_NONE);
      take(5'b00111, 1'b0, 1'b0, EXC_NORMAL, EXC_NONE);
      take(5'b00111, 1'b1, 1'b0, EXC_PABORT, EXC_NONE);
      take(5'b00011, 1'b1, 1'b0, EXC_UNDEF, EXC_NONE);
      take(5'b00001, 1'b1, 1'b0, EXC_TRAP, EXC_NONE);
      src <= 32'h21;
      take(5'b01000, 1'b1, 1'b1, EXC_DABORT, EXC_FAST);
      take(5'b00111, 1'b0, 1'b1, EXC_FAST, EXC_NONE);
      // a pending normal waits while the fast handler runs
      t1f <= 1'b1;
      wait_take();
      chk({29'h0, exc_code}, {29'h0, EXC_FAST});
      @(posedge pclk);
      t1f <= 1'b0;
      nd <= 1'b0;
      repeat (6) begin
         @(negedge pclk);
         chk({31'h0, exc_take}, 32'h0);
      end
      @(posedge pclk);
      fret <= 1'b1;
      @(posedge pclk);
      fret <= 1'b0;
      wait_take();
      chk({29'h0, exc_code}, {29'h0, EXC_NORMAL});
      @(posedge pclk);
      nd <= 1'b1;
      // a reset in mid-run brings back the mask and the fast disable flag
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      chk({31'h0, fast_disable}, 32'h1);
      rdchk(ADDR_MASK, MASK_RESET);
      chk({31'h0, normal_irq}, 32'h0);
      results();
   end
endmodule
`default_nettype wire
